// ---- slave_host_handshake.sv ----
`timescale 1ns/1ps
// Function
// - Freeze command sets freeze flag
// - Unfreeze, link stop or reset clear freeze
// - Freeze lamp follows freeze flag
// - Watchdog flag sticky until reset only
// - Mode change writes result, raises done
// - Mode done drops when request drops
// - Done on failure too; keep old mode
// - Station done raised, dropped with request
// - Station result reported; error keeps old number
// - Station request suspends cyclic exchange
// - Ready raised once host access possible
// - Ready dropped on watchdog or hardware fault
// - Refresh on and link active send inputs
// - Refresh off sends all-zero input data
// - Refresh ignored while link inactive
// - Trouble request sends trouble words if linked
// - Error clear drops flag, lamp, code
// - Mode request starts switch to written mode
// - Station request starts change to written number
// - Class 2 lock refuses changes until host request
// - Link active updates output receive area
// - Error sets module error flag and code
// - Trouble done raised, dropped with request
module slave_host_handshake (
   input  wire logic        core_clk,
   input  wire logic        rstn,

   // Host CPU buffer memory port
   input  wire logic [11:0] bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic        bus_wr,
   output logic      [15:0] bus_rdata,

   // Host request pins
   input  wire logic        input_refresh_enable,
   input  wire logic        trouble_notify_req,
   input  wire logic        error_clear_req,
   input  wire logic        mode_change_req,
   input  wire logic        station_change_req,

   // Host status outputs
   output logic             link_active,
   output logic             trouble_notify_done,
   output logic             module_error_flag,
   output logic             freeze_mode_flag,
   output logic             watchdog_error_flag,
   output logic             mode_change_done,
   output logic             station_change_done,
   output logic             host_access_ready,
   output logic             freeze_lamp,
   output logic             error_lamp,

   // Protocol engine side, same clock
   input  wire logic        comm_ok,
   input  wire logic        freeze_cmd,
   input  wire logic        unfreeze_cmd,
   input  wire logic        wdt_fault,
   input  wire logic        hw_fault,
   input  wire logic        error_event,
   input  wire logic [15:0] error_event_code,
   input  wire logic        c2_station_set,
   input  wire logic [15:0] c2_station_num,
   input  wire logic        c2_no_change,
   input  wire logic        out_wr,
   input  wire logic [7:0]  out_idx,
   input  wire logic [15:0] out_data,
   input  wire logic        in_rd,
   input  wire logic [7:0]  in_idx,
   output logic             in_valid,
   output logic      [15:0] in_data,
   output logic             trouble_valid,
   output logic      [15:0] trouble_data,
   output logic      [15:0] active_station
);
   import slave_hs_pkg::*;

   typedef struct packed {
      logic [HP_COUNT-1:0] req_prev;
      logic                link_act;
      logic                freeze;
      logic                wdt_err;
      logic                mod_err;
      logic [15:0]         err_code;
      logic                ready;

      logic                mode_done;
      logic [15:0]         mode_now;
      logic [15:0]         mode_req;
      logic [15:0]         mode_result;

      logic                st_done;
      logic                st_suspend;
      logic [15:0]         station;
      logic [15:0]         station_req;
      logic                st_lock;

      trouble_state_e      t_state;
      logic [3:0]          t_cnt;
      logic                t_pend;
      logic                t_valid;
      logic [15:0]         t_data;
      logic                t_done;

      logic                rd_pend;
      logic                rd_zero;
      logic                rd_reg_pend;
      logic [11:0]         rd_reg_addr;
      logic                in_v;
      logic [15:0]         in_d;
      logic [15:0]         rdata;
   } state_s;

   state_s              st_reg;
   state_s              st_next;
   logic [HP_COUNT-1:0] req_sync;
   logic [HP_COUNT-1:0] req_rise;
   logic [15:0]         mem_bus_data;
   logic [15:0]         mem_in_data;
   logic [15:0]         mem_tr_data;

   logic                host_wr_en;
   logic                out_wr_en;
   logic [11:0]         out_addr;
   logic [11:0]         in_addr;
   logic [11:0]         tr_addr;
   logic                exchange_on;

   // Host pins come from another domain, so they pass two flip-flops
   pin_sync #(.W(HP_COUNT)) u_pin_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .pin_in   ({station_change_req, mode_change_req, error_clear_req,
                  trouble_notify_req, input_refresh_enable}),
      .pin_out  (req_sync)
   );

   // Request actions start on the rising transition only
   assign req_rise = req_sync & ~st_reg.req_prev;

   // Cyclic exchange runs with the link up and no station change open
   assign exchange_on = comm_ok && !st_reg.st_suspend;

   // Status words live in registers; host writes there are not stored
   assign host_wr_en = bus_wr && (bus_addr > ADDR_OUTPUT_RECV_LAST)
                       && (bus_addr != ADDR_ACTIVE_STATION)
                       && (bus_addr != ADDR_ERROR_CODE)
                       && (bus_addr != ADDR_MODE_RESULT)
                       && (bus_addr != ADDR_MODE_CURRENT);
   assign out_wr_en  = out_wr && exchange_on
                       && (out_idx <= ADDR_OUTPUT_RECV_LAST[7:0]);
   assign out_addr   = {4'h0, out_idx};
   assign in_addr    = ADDR_INPUT_SEND_FIRST + {4'h0, in_idx};
   assign tr_addr    = ADDR_TROUBLE_FIRST + {8'h00, st_reg.t_cnt};

   buffer_mem u_buffer_mem (
      .core_clk  (core_clk),
      .wr_a_en   (host_wr_en),
      .wr_a_addr (bus_addr),
      .wr_a_data (bus_wdata),
      .wr_b_en   (out_wr_en),
      .wr_b_addr (out_addr),
      .wr_b_data (out_data),
      .rd_a_addr (bus_addr),
      .rd_a_data (mem_bus_data),
      .rd_b_addr (in_addr),
      .rd_b_data (mem_in_data),
      .rd_c_addr (tr_addr),
      .rd_c_data (mem_tr_data)
   );

   // Next-state logic for every flag and handshake
   always_comb begin
      st_next          = st_reg;
      st_next.req_prev = req_sync;
      st_next.link_act = exchange_on;

      // Freeze follows master commands; link loss ends it
      if (!comm_ok || unfreeze_cmd) begin
         st_next.freeze = 1'b0;
      end else if (freeze_cmd) begin
         st_next.freeze = 1'b1;
      end

      // Watchdog error is cleared by reset alone, not by error clear
      if (wdt_fault) begin
         st_next.wdt_err = 1'b1;
      end

      // Host access stays open until a watchdog or hardware fault
      st_next.ready = !(wdt_fault || st_reg.wdt_err || hw_fault);

      // Error clear first, so a same-cycle error event wins
      if (req_rise[HP_ERRCLR]) begin
         st_next.mod_err  = 1'b0;
         st_next.err_code = WORD_ZERO;
      end

      // Host copies of the request words
      if (bus_wr && bus_addr == ADDR_NEW_STATION_REQ) begin
         st_next.station_req = bus_wdata;
      end

      if (bus_wr && bus_addr == ADDR_MODE_REQ) begin
         st_next.mode_req = bus_wdata;
      end

      // Mode change finishes in one cycle; a bad mode leaves the old one
      if (req_rise[HP_MODE]) begin
         if (st_reg.mode_req <= MODE_MAX) begin
            st_next.mode_now    = st_reg.mode_req;
            st_next.mode_result = MODE_RESULT_OK;
         end else begin
            st_next.mode_result = MODE_RESULT_BAD;
         end
         st_next.mode_done = 1'b1;
      end else if (!req_sync[HP_MODE]) begin
         st_next.mode_done = 1'b0;
      end

      // Class 2 master may set the number unless the lock is on
      if (c2_station_set && !st_reg.st_lock) begin
         if (c2_station_num <= STATION_MAX) begin
            st_next.station = c2_station_num;
            st_next.st_lock = c2_no_change;
         end
      end

      // Host station change clears the lock and applies a number up to STATION_MAX
      if (req_rise[HP_STATION]) begin
         st_next.st_suspend = 1'b1;
         st_next.st_lock    = 1'b0;
         if (st_reg.station_req <= STATION_MAX) begin
            st_next.station = st_reg.station_req;
         end else begin
            st_next.mod_err  = 1'b1;
            st_next.err_code = ERR_STATION_NUMBER;
         end
         st_next.st_done = 1'b1;
      end else if (!req_sync[HP_STATION]) begin
         st_next.st_done = 1'b0;
      end

      // Exchange resumes once completion is shown
      if (st_reg.st_done) begin
         st_next.st_suspend = 1'b0;
      end

      // Any detected error latches flag and code; overrides a clear
      if (error_event) begin
         st_next.mod_err  = 1'b1;
         st_next.err_code = error_event_code;
      end

      // Input send reads: refresh off or link down gives zero data
      st_next.rd_pend = in_rd;
      st_next.rd_zero = !(req_sync[HP_REFRESH]
                          && exchange_on);
      st_next.in_v    = st_reg.rd_pend;
      st_next.in_d    = st_reg.rd_zero ? WORD_ZERO : mem_in_data;

      // Trouble words stream out one per cycle, then done waits for the fall
      st_next.t_pend  = 1'b0;
      st_next.t_valid = st_reg.t_pend;
      st_next.t_data  = mem_tr_data;
      case (st_reg.t_state)
         T_IDLE: begin
            st_next.t_cnt = 4'h0;
            if (req_rise[HP_TROUBLE] && exchange_on) begin
               st_next.t_state = T_SEND;
            end
         end

         T_SEND: begin
            st_next.t_pend = 1'b1;
            if (st_reg.t_cnt == TROUBLE_WORDS - 4'h1) begin
               st_next.t_state = T_DONE;
            end else begin
               st_next.t_cnt = st_reg.t_cnt + 4'h1;
            end
         end

         T_DONE: begin
            // Raised after the last word has left the pipeline
            if (!req_sync[HP_TROUBLE]
                && !st_reg.t_pend && !st_reg.t_valid) begin
               st_next.t_state = T_IDLE;
            end
         end

         default: begin
            st_next.t_state = T_IDLE;
         end
      endcase
      // Done pin from a flip-flop
      st_next.t_done = st_next.t_state == T_DONE
                       && !st_next.t_pend && !st_next.t_valid;

      // Host reads: registered words first, else buffer memory
      st_next.rd_reg_addr = bus_addr;
      case (st_reg.rd_reg_addr)
         ADDR_ACTIVE_STATION: st_next.rdata = st_reg.station;
         ADDR_ERROR_CODE:     st_next.rdata = st_reg.err_code;
         ADDR_MODE_RESULT:    st_next.rdata = st_reg.mode_result;
         ADDR_MODE_CURRENT:   st_next.rdata = st_reg.mode_now;
         default:             st_next.rdata = mem_bus_data;
      endcase
   end

   // One register stage for all state
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_reg             <= '0;
         st_reg.t_state     <= T_IDLE;
         st_reg.station     <= STATION_RESET;
         st_reg.mode_now    <= MODE_RESET;
         st_reg.mode_result <= MODE_RESULT_OK;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign bus_rdata           = st_reg.rdata;
   assign link_active         = st_reg.link_act;
   assign trouble_notify_done = st_reg.t_done;
   assign module_error_flag   = st_reg.mod_err;
   assign error_lamp          = st_reg.mod_err;
   assign freeze_mode_flag    = st_reg.freeze;
   assign freeze_lamp         = st_reg.freeze;
   assign watchdog_error_flag = st_reg.wdt_err;
   assign mode_change_done    = st_reg.mode_done;
   assign station_change_done = st_reg.st_done;
   assign host_access_ready   = st_reg.ready;

   assign in_valid            = st_reg.in_v;
   assign in_data             = st_reg.in_d;
   assign trouble_valid       = st_reg.t_valid;
   assign trouble_data        = st_reg.t_data;
   assign active_station      = st_reg.station;
endmodule : slave_host_handshake

// ---- slave_hs_pkg.sv ----
package slave_hs_pkg;
   // Buffer memory word addresses seen by the host CPU
   localparam logic [11:0] ADDR_INPUT_SEND_FIRST = 12'h100;
   localparam logic [11:0] ADDR_INPUT_SEND_LAST  = 12'h1BF;
   localparam logic [11:0] ADDR_OUTPUT_RECV_LAST = 12'h0BF;
   localparam logic [11:0] ADDR_ACTIVE_STATION   = 12'h201;
   localparam logic [11:0] ADDR_NEW_STATION_REQ  = 12'h203;
   localparam logic [11:0] ADDR_ERROR_CODE       = 12'h7F8;
   localparam logic [11:0] ADDR_TROUBLE_FIRST    = 12'h7F9;
   localparam logic [11:0] ADDR_MODE_CURRENT     = 12'h8CE;
   localparam logic [11:0] ADDR_MODE_REQ         = 12'h8CF;
   localparam logic [11:0] ADDR_MODE_RESULT      = 12'h8D0;
   // Trouble information block length in words
   localparam logic [3:0]  TROUBLE_WORDS         = 4'hD;
   // Station and mode checks
   localparam logic [15:0] STATION_MAX           = 16'h007D;
   localparam logic [15:0] MODE_MAX              = 16'h0003;
   localparam logic [15:0] ERR_STATION_NUMBER    = 16'h1002;
   localparam logic [15:0] MODE_RESULT_OK        = 16'h0000;
   localparam logic [15:0] MODE_RESULT_BAD       = 16'h0001;
   // Reset values
   localparam logic [15:0] STATION_RESET         = 16'h0000;
   localparam logic [15:0] MODE_RESET            = 16'h0000;
   localparam logic [15:0] WORD_ZERO             = 16'h0000;
   // Host request pin bit positions
   localparam int          HP_REFRESH            = 0;
   localparam int          HP_TROUBLE            = 1;
   localparam int          HP_ERRCLR             = 2;
   localparam int          HP_MODE               = 3;
   localparam int          HP_STATION            = 4;
   localparam int          HP_COUNT              = 5;

   // Trouble notification sequencer, Gray along idle-send-done
   typedef enum logic [1:0] {
      T_IDLE = 2'b00,
      T_SEND = 2'b01,
      T_DONE = 2'b11
   } trouble_state_e;
endpackage : slave_hs_pkg

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 5
) (
   input  wire logic         core_clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } sync_s;

   sync_s st_reg;
   sync_s st_next;

   // First stage feeds only the second stage
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < W; i++) begin
         st_next.stage1[i] = pin_in[i];
         st_next.stage2[i] = st_reg.stage1[i];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pin_out = st_reg.stage2;
endmodule : pin_sync

// ---- buffer_mem.sv ----
`timescale 1ns/1ps
module buffer_mem (
   input  wire logic        core_clk,
   input  wire logic        wr_a_en,
   input  wire logic [11:0] wr_a_addr,
   input  wire logic [15:0] wr_a_data,
   input  wire logic        wr_b_en,
   input  wire logic [11:0] wr_b_addr,
   input  wire logic [15:0] wr_b_data,
   input  wire logic [11:0] rd_a_addr,
   output logic      [15:0] rd_a_data,
   input  wire logic [11:0] rd_b_addr,
   output logic      [15:0] rd_b_data,
   input  wire logic [11:0] rd_c_addr,
   output logic      [15:0] rd_c_data
);
   logic [15:0] mem [0:4095];

   // Write ports cover disjoint areas, so they never hit one word together
   always_ff @(posedge core_clk) begin
      if (wr_a_en) begin
         mem[wr_a_addr] <= wr_a_data;
      end
      if (wr_b_en) begin
         mem[wr_b_addr] <= wr_b_data;
      end
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
      rd_c_data <= mem[rd_c_addr];
   end
endmodule : buffer_mem

// ---- slave_host_handshake_sva.sv ----
`timescale 1ns/1ps
module slave_host_handshake_sva (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        comm_ok,
   input  wire logic        freeze_cmd,
   input  wire logic        unfreeze_cmd,
   input  wire logic        wdt_fault,
   input  wire logic        hw_fault,
   input  wire logic        error_event,
   input  wire logic        mode_change_req,
   input  wire logic        station_change_req,
   input  wire logic        in_valid,
   input  wire logic [15:0] in_data,
   input  wire logic        freeze_mode_flag,
   input  wire logic        freeze_lamp,
   input  wire logic        watchdog_error_flag,
   input  wire logic        host_access_ready,
   input  wire logic        mode_change_done,
   input  wire logic        station_change_done,
   input  wire logic        module_error_flag,
   input  wire logic        error_lamp
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Request steps; pin sync adds two cycles before any action
   sequence s_mode_up;
      $rose(mode_change_req);
   endsequence
   sequence s_station_up;
      $rose(station_change_req);
   endsequence
   a_lamp_follows: assert property (freeze_lamp == freeze_mode_flag)
      else $error("freeze lamp differs from flag");
   a_freeze_on: assert property (freeze_cmd && comm_ok && !unfreeze_cmd |-> ##[1:2] freeze_mode_flag)
      else $error("freeze flag not set");
   a_freeze_off: assert property ((unfreeze_cmd || !comm_ok) && !freeze_cmd |-> ##[1:2] !freeze_mode_flag)
      else $error("freeze flag not cleared");
   a_wdt_sticky: assert property (wdt_fault || watchdog_error_flag |=> watchdog_error_flag)
      else $error("watchdog flag lost");
   a_ready_drop: assert property (watchdog_error_flag || hw_fault |-> ##[0:2] !host_access_ready)
      else $error("ready stays high after fault");
   a_mode_done: assert property (s_mode_up |-> ##[1:5] mode_change_done)
      else $error("mode done late");
   a_mode_release: assert property ($fell(mode_change_req) |-> ##[1:6] !mode_change_done)
      else $error("mode done held");
   a_station_done: assert property (s_station_up |-> ##[1:5] station_change_done)
      else $error("station done late");
   a_zero_input: assert property (in_valid && !$past(comm_ok, 2) |-> in_data == 16'h0000)
      else $error("input data sent without link");
   a_error_set: assert property (error_event |-> ##[1:2] module_error_flag)
      else $error("error flag not set");
   a_error_lamp: assert property (error_lamp == module_error_flag)
      else $error("error lamp differs from flag");
endmodule : slave_host_handshake_sva

bind slave_host_handshake slave_host_handshake_sva i_sva (.*);

// ---- master_model.sv ----
`timescale 1ns/1ps
module master_model (
   input  wire logic        core_clk,
   output logic             comm_ok,
   output logic             freeze_cmd,
   output logic             unfreeze_cmd,
   output logic             out_wr,
   output logic [7:0]       out_idx,
   output logic [15:0]      out_data,
   output logic             in_rd,
   output logic [7:0]       in_idx,
   input  wire logic        in_valid,
   input  wire logic [15:0] in_data,
   input  wire logic        trouble_valid,
   input  wire logic [15:0] trouble_data
);
   logic [15:0] tq[$];
   // Link up at start, all strobes quiet
   initial begin
      {comm_ok, freeze_cmd, unfreeze_cmd, out_wr, in_rd} = 5'h10;
      {out_idx, in_idx, out_data} = '0;
   end
   // Collect trouble words as the slave streams them
   always @(posedge core_clk) begin
      if (trouble_valid) tq.push_back(trouble_data);
   end
   task automatic set_link(input logic up);
      @(posedge core_clk);
      comm_ok <= up;
   endtask : set_link
   task automatic command(input logic frz, input logic unfrz);
      @(posedge core_clk);
      freeze_cmd   <= frz;
      unfreeze_cmd <= unfrz;
      @(posedge core_clk);
      freeze_cmd   <= 1'b0;
      unfreeze_cmd <= 1'b0;
   endtask : command
   // Released lines show inverted data so stale values cannot pass
   task automatic send_output(input logic [7:0] idx, input logic [15:0] d);
      @(posedge core_clk);
      out_wr   <= 1'b1;
      out_idx  <= idx;
      out_data <= d;
      @(posedge core_clk);
      out_wr   <= 1'b0;
      out_idx  <= ~idx;
      out_data <= ~d;
   endtask : send_output
   task automatic fetch_input(input logic [7:0] idx, output logic [15:0] d);
      d = 16'hBAD0;
      @(posedge core_clk);
      in_rd  <= 1'b1;
      in_idx <= idx;
      @(posedge core_clk);
      in_rd  <= 1'b0;
      in_idx <= ~idx;
      repeat (4) begin
         @(posedge core_clk);
         #1;
         if (in_valid === 1'b1) begin
            d = in_data;
            break;
         end
      end
   endtask : fetch_input
endmodule : master_model

// ---- test_slave_host_handshake.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
`define WAIT_FOR(c) repeat (40) begin @(posedge core_clk); #1; if ((c) === 1'b1) break; end
module test_slave_host_handshake;
   import slave_hs_pkg::*;
   logic        core_clk, rstn, bus_wr, input_refresh_enable, trouble_notify_req;
   logic        error_clear_req, mode_change_req, station_change_req, wdt_fault, hw_fault;
   logic        error_event, c2_station_set, c2_no_change, comm_ok, freeze_cmd;
   logic        unfreeze_cmd, out_wr, in_rd, in_valid, trouble_valid, link_active;
   logic        trouble_notify_done, module_error_flag, freeze_mode_flag, watchdog_error_flag;
   logic        mode_change_done, station_change_done, host_access_ready, freeze_lamp;
   logic        error_lamp;
   logic [7:0]  out_idx, in_idx;
   logic [11:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, error_event_code, c2_station_num, out_data, in_data;
   logic [15:0] trouble_data, active_station, rd;
   int          n_fail, n_compared, cyc;
   slave_host_handshake i_dut (.*);
   master_model i_master (.*);
   // Free running clock, 50 MHz
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic bus_write(input logic [11:0] a, input logic [15:0] d);
      @(posedge core_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge core_clk);
      bus_wr    <= 1'b0;
   endtask : bus_write
   // Address is held past the two-cycle read latency
   task automatic bus_read(input logic [11:0] a);
      @(posedge core_clk);
      bus_addr <= a;
      repeat (3) @(posedge core_clk);
      #1;
      rd = bus_rdata;
   endtask : bus_read
   task automatic do_mode(input logic [15:0] m, input logic [15:0] res);
      bus_write(ADDR_MODE_REQ, m);
      @(posedge core_clk);
      mode_change_req <= 1'b1;
      `WAIT_FOR(mode_change_done)
      `CHK(mode_change_done, 1'b1)
      bus_read(ADDR_MODE_RESULT);
      `CHK(rd, res)
      bus_read(ADDR_MODE_CURRENT);
      `CHK(rd, 16'h0002)
      @(posedge core_clk);
      mode_change_req <= 1'b0;
      `WAIT_FOR(!mode_change_done)
      `CHK(mode_change_done, 1'b0)
   endtask : do_mode
   task automatic do_station(input logic [15:0] n, input logic err);
      bus_write(ADDR_NEW_STATION_REQ, n);
      @(posedge core_clk);
      station_change_req <= 1'b1;
      `WAIT_FOR(station_change_done)
      @(posedge core_clk);
      #1 `CHK(link_active, 1'b0)
      `CHK(active_station, STATION_MAX)
      bus_read(ADDR_ACTIVE_STATION);
      `CHK(rd, STATION_MAX)
      `CHK(module_error_flag, err)
      @(posedge core_clk);
      station_change_req <= 1'b0;
      `WAIT_FOR(!station_change_done)
      `CHK(station_change_done, 1'b0)
      `CHK(link_active, 1'b1)
   endtask : do_station
   task automatic t_start();
      `WAIT_FOR(host_access_ready)
      `CHK(host_access_ready, 1'b1)
      `CHK({freeze_mode_flag, watchdog_error_flag, module_error_flag}, 3'h0)
      bus_read(ADDR_ACTIVE_STATION);
      `CHK(rd, STATION_RESET)
      $display("t_start finished");
   endtask : t_start
   task automatic t_freeze();
      i_master.command(1'b1, 1'b0);
      `WAIT_FOR(freeze_mode_flag)
      `CHK(freeze_lamp, 1'b1)
      i_master.command(1'b0, 1'b1);
      `WAIT_FOR(!freeze_mode_flag)
      `CHK(freeze_mode_flag, 1'b0)
      i_master.command(1'b1, 1'b0);
      i_master.set_link(1'b0);
      `WAIT_FOR(!freeze_lamp)
      `CHK(freeze_mode_flag, 1'b0)
      i_master.set_link(1'b1);
      $display("t_freeze finished");
   endtask : t_freeze
   task automatic t_mode_station();
      do_mode(16'h0002, MODE_RESULT_OK);
      do_mode(MODE_MAX + 16'h0001, MODE_RESULT_BAD);
      {c2_station_num, c2_no_change, c2_station_set} <= {16'h0005, 2'b11};
      @(posedge core_clk);
      c2_station_num <= 16'h0006;
      repeat (2) @(posedge core_clk);
      c2_station_set <= 1'b0;
      `CHK(active_station, 16'h0005)
      do_station(STATION_MAX, 1'b0);
      do_station(STATION_MAX + 16'h0001, 1'b1);
      bus_read(ADDR_ERROR_CODE);
      `CHK(rd, ERR_STATION_NUMBER)
      @(posedge core_clk);
      error_clear_req <= 1'b1;
      `WAIT_FOR(!module_error_flag)
      `CHK(error_lamp, 1'b0)
      bus_read(ADDR_ERROR_CODE);
      `CHK(rd, WORD_ZERO)
      error_clear_req <= 1'b0;
      $display("t_mode_station finished");
   endtask : t_mode_station
   task automatic t_refresh();
      bus_write(ADDR_INPUT_SEND_FIRST + 12'h001, 16'hA5A5);
      input_refresh_enable <= 1'b1;
      repeat (4) @(posedge core_clk);
      i_master.fetch_input(8'h01, rd);
      `CHK(rd, 16'hA5A5)
      input_refresh_enable <= 1'b0;
      repeat (4) @(posedge core_clk);
      i_master.fetch_input(8'h01, rd);
      `CHK(rd, WORD_ZERO)
      i_master.send_output(8'h03, 16'h1234);
      bus_read(12'h003);
      `CHK(rd, 16'h1234)
      input_refresh_enable <= 1'b1;
      i_master.set_link(1'b0);
      repeat (4) @(posedge core_clk);
      i_master.fetch_input(8'h01, rd);
      `CHK(rd, WORD_ZERO)
      i_master.send_output(8'h03, 16'h5678);
      bus_read(12'h003);
      `CHK(rd, 16'h1234)
      $display("t_refresh finished");
   endtask : t_refresh
   task automatic t_trouble();
      for (int i = 0; i < 13; i++) bus_write(ADDR_TROUBLE_FIRST + i[11:0], 16'hC000 + i[15:0]);
      trouble_notify_req <= 1'b1;
      repeat (12) @(posedge core_clk);
      `CHK(trouble_notify_done, 1'b0)
      trouble_notify_req <= 1'b0;
      i_master.set_link(1'b1);
      repeat (8) @(posedge core_clk);
      trouble_notify_req <= 1'b1;
      `WAIT_FOR(trouble_notify_done)
      `CHK(trouble_notify_done, 1'b1)
      `CHK(i_master.tq.size(), int'(TROUBLE_WORDS))
      foreach (i_master.tq[i]) `CHK(i_master.tq[i], 16'hC000 + i[15:0])
      @(posedge core_clk);
      trouble_notify_req <= 1'b0;
      `WAIT_FOR(!trouble_notify_done)
      `CHK(trouble_notify_done, 1'b0)
      $display("t_trouble finished");
   endtask : t_trouble
   task automatic t_watchdog();
      @(posedge core_clk);
      error_event      <= 1'b1;
      error_event_code <= 16'h2222;
      @(posedge core_clk);
      error_event <= 1'b0;
      bus_read(ADDR_ERROR_CODE);
      `CHK(rd, 16'h2222)
      wdt_fault <= 1'b1;
      @(posedge core_clk);
      wdt_fault       <= 1'b0;
      error_clear_req <= 1'b1;
      repeat (8) @(posedge core_clk);
      `CHK({watchdog_error_flag, host_access_ready}, 2'b10)
      error_clear_req <= 1'b0;
      rstn            <= 1'b0;
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      `WAIT_FOR(host_access_ready)
      `CHK({watchdog_error_flag, host_access_ready}, 2'b01)
      hw_fault <= 1'b1;
      repeat (2) @(posedge core_clk);
      `CHK(host_access_ready, 1'b0)
      hw_fault <= 1'b0;
      $display("t_watchdog finished");
   endtask : t_watchdog
   // Main sequence: all inputs quiet, reset for six cycles
   initial begin
      {rstn, bus_wr, input_refresh_enable, trouble_notify_req, error_clear_req} = '0;
      {mode_change_req, station_change_req, wdt_fault, hw_fault, error_event} = '0;
      {c2_station_set, c2_no_change, bus_addr, bus_wdata} = '0;
      {error_event_code, c2_station_num} = '0;
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      t_start();
      t_freeze();
      t_mode_station();
      t_refresh();
      t_trouble();
      t_watchdog();
      give_verdict();
   end
endmodule : test_slave_host_handshake
